// [bench/increment_skip_instructions_tb_top.sv]
`timescale 1ns/100ps
`default_nettype none
module increment_skip_instructions_tb_top;
    logic sys_clk = 1'b0, sys_rst = 1'b1, phaseStep = 1'b0, instrValid = 1'b0;
    logic nextIsTwoWord = 1'b0, extendedSet = 1'b0;
    logic [15:0] instrWord = 16'h0000;
    logic [3:0] bank_select_register = 4'h0;
    logic [11:0] indexBase = 12'h000, memAddr;
    logic [7:0] memReadData, memWriteData, accWriteData;
    logic memRead, memWrite, accWrite, discardFetched, nopCycle, busy;
    logic [1:0] phase;
    integer err_total = 0, cmp_count = 0, seed = 90;
    incsk_core incsk_core_inst (.sys_clk, .sys_rst, .phaseStep, .instrWord, .instrValid,
        .nextIsTwoWord, .extendedSet, .bank_select_register, .indexBase, .memReadData,
        .memAddr, .memRead, .memWrite, .memWriteData, .accWrite, .accWriteData,
        .discardFetched, .nopCycle, .busy, .phase);
    incsk_mem_model incsk_mem_model_inst (.sys_clk, .memAddr, .memRead, .memWrite,
        .memWriteData, .memReadData);
    initial forever #5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) phaseStep <= ~phaseStep;
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic give_verdict();
        $display("compares %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic run(input logic [1:0] op, input logic [7:0] v);
        logic [7:0] f, r;
        logic [3:0] b;
        logic [11:0] ib, ea;
        logic d, a, x, t, s, bz, ds;
        logic [15:0] wm, wa, np, bc;
        {f, d, a, b, x, t} = 16'($random(seed));
        ib = 12'($random(seed));
        r = v + 8'h01;
        s = (op == 2'h0) ? (r == 8'h00) : (op == 2'h1 && r != 8'h00);
        if (a) ea = {b, f};
        else if (x && f <= 8'h5F) ea = ib + {4'h0, f};
        else ea = {(f >= 8'h60) ? 4'hF : 4'h0, f};
        incsk_mem_model_inst.mem[ea] = v;
        {bz, ds, wm, wa, np, bc} = '0;
        for (int n = 0; n < 20 && (phase !== 2'h0 || busy !== 1'b0 || phaseStep); n++)
            @(posedge sys_clk);
        instrWord <= {(op == 2'h0) ? 6'b001111 : (op == 2'h1) ? 6'b010010 : 6'b010000, d, a, f};
        instrValid <= 1'b1;
        nextIsTwoWord <= t;
        extendedSet <= x;
        bank_select_register <= b;
        indexBase <= ib;
        @(posedge sys_clk);
        instrValid <= 1'b0;
        repeat (40) begin
            @(posedge sys_clk);
            if (memRead === 1'b1) check(16'(memAddr), 16'(ea));
            if (memWrite === 1'b1) check(16'(memWriteData), 16'(r));
            if (accWrite === 1'b1) check(16'(accWriteData), 16'(r));
            bz |= busy;
            ds |= discardFetched;
            wm += 16'(memWrite);
            wa += 16'(accWrite);
            np += 16'(phaseStep && nopCycle);
            bc += 16'(busy);
            // offer a valid word during no-op cycles, to be refused
            instrValid <= nopCycle;
        end
        check(bc, (op == 2'h2) ? 16'h0000 : s ? (t ? 16'h0016 : 16'h000E) : 16'h0006);
        check(16'(bz), 16'(op != 2'h2));
        check(wm, 16'(op != 2'h2 && d));
        check(wa, 16'(op != 2'h2 && !d));
        check(16'(ds), 16'(s));
        check(np, s ? (t ? 16'h0008 : 16'h0004) : 16'h0000);
    endtask
    initial begin
        repeat (20) @(posedge sys_clk);
        sys_rst <= 1'b0;
        for (int i = 0; i < 60; i++)
            run(2'(i % 3), (i % 4 == 0) ? 8'hFF : 8'($random(seed)));
        give_verdict();
    end
    // about three times the planned run
    initial begin
        #100000;
        err_total++;
        give_verdict();
    end
endmodule // increment_skip_instructions_tb_top
`default_nettype wire

// [bench/incsk_core_checker.sv]
`timescale 1ns/100ps
`default_nettype none
module incsk_core_checker (
    input wire logic        sys_clk,
    input wire logic        sys_rst,
    input wire logic        phaseStep,
    input wire logic [11:0] memAddr,
    input wire logic        memRead,
    input wire logic        memWrite,
    input wire logic        accWrite,
    input wire logic        discardFetched,
    input wire logic        nopCycle,
    input wire logic        busy,
    input wire logic [1:0]  phase
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    a_read_phase: assert property (memRead |-> busy && phase == 2'h1)
        else $error("read outside phase one");
    a_read_addr: assert property (memRead && !phaseStep |=> memRead && $stable(memAddr))
        else $error("read address moved");
    a_discard_step: assert property (discardFetched |-> phaseStep && phase == 2'h3)
        else $error("discard off the last step");
    a_nop_after: assert property (discardFetched |=> nopCycle [*2])
        else $error("no idle cycle after discard");
    a_mem_write: assert property (memWrite |-> $past(phaseStep) && $past(phase) == 2'h3)
        else $error("memory write mistimed");
    a_acc_write: assert property (accWrite |-> $past(phaseStep) && !memWrite)
        else $error("accumulator write mistimed");
    a_phase_hold: assert property (!phaseStep |=> $stable(phase))
        else $error("phase moved without step");
    a_nop_busy: assert property (nopCycle |-> busy)
        else $error("idle cycle while not busy");
    a_nop_quiet: assert property (nopCycle |=> !memRead && !memWrite && !accWrite)
        else $error("access during no-op cycle");
    cover property (discardFetched);
    cover property (memWrite);
    cover property (accWrite);
endmodule // incsk_core_checker
bind incsk_core incsk_core_checker incsk_core_checker_inst (.sys_clk, .sys_rst, .phaseStep,
    .memAddr, .memRead, .memWrite, .accWrite, .discardFetched, .nopCycle, .busy, .phase);
`default_nettype wire

// [bench/incsk_mem_model.sv]
`timescale 1ns/100ps
`default_nettype none
module incsk_mem_model (
    input  wire logic        sys_clk,
    input  wire logic [11:0] memAddr,
    input  wire logic        memRead,
    input  wire logic        memWrite,
    input  wire logic [7:0]  memWriteData,
    output logic      [7:0]  memReadData
);
    logic [7:0] mem [4096];
    logic [7:0] idle = 8'h00;
    // not reading: show a changing pattern
    assign memReadData = memRead ? mem[memAddr] : idle;
    always @(posedge sys_clk) begin
        idle <= ~memReadData;
        if (memWrite) mem[memAddr] <= memWriteData;
    end
endmodule // incsk_mem_model
`default_nettype wire

// [rtl/incsk_core.sv]
`timescale 1ns/100ps
`default_nettype none

module incsk_core (
    input  wire logic                       sys_clk,
    input  wire logic                       sys_rst,
    input  wire logic                       phaseStep,
    input  wire logic [15:0]                instrWord,
    input  wire logic                       instrValid,
    input  wire logic                       nextIsTwoWord,
    input  wire logic                       extendedSet,
    input  wire logic [3:0]                 bank_select_register,
    input  wire logic [11:0]                indexBase,
    input  wire logic [7:0]                 memReadData,
    output logic [11:0]                     memAddr,
    output logic                            memRead,
    output logic                            memWrite,
    output logic [7:0]                      memWriteData,
    output logic                            accWrite,
    output logic [7:0]                      accWriteData,
    output logic                            discardFetched,
    output logic                            nopCycle,
    output logic                            busy,
    output logic [1:0]                      phase
);

    typedef enum logic [1:0] {
        INCSK_IDLE,
        INCSK_EXEC,
        INCSK_NOP1,
        INCSK_NOP2
    } incsk_state_t;

    incsk_state_t             state;
    incsk_pkg::incsk_decode_t decoded;
    incsk_pkg::incsk_decode_t held;
    logic [7:0]               operand;
    logic [7:0]               result;
    logic [11:0]              next_addr;
    logic                     takeSkip;
    logic                     twoWordHeld;
    logic                     cycleEnd;
    logic                     decodeStep;
    logic                     readStep;
    logic                     processStep;
    logic                     acceptWord;
    logic                     resultZero;
    logic                     writeMem;
    logic                     writeAcc;

    incsk_decoder u_decoder (
        .instrWord   (instrWord),
        .extendedSet (extendedSet),
        .decoded     (decoded)
    );

    // one strobe per phase of the instruction cycle
    assign decodeStep  = phaseStep && (phase == incsk_pkg::PHASE_DECODE);
    assign readStep    = phaseStep && (phase == incsk_pkg::PHASE_READ);
    assign processStep = phaseStep && (phase == incsk_pkg::PHASE_PROCESS);
    assign cycleEnd    = phaseStep && (phase == incsk_pkg::PHASE_WRITE);

    // no new word while a skipped slot is being filled
    assign acceptWord  = decodeStep && (state == INCSK_IDLE);

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            phase <= incsk_pkg::PHASE_RESET;
        end else if (phaseStep) begin
            phase <= phase + 2'h1;
        end
    end

    always_comb begin
        unique case (decoded.mode)
            incsk_pkg::INCSK_MODE_BANKED:
                next_addr = {bank_select_register, decoded.offset};
            incsk_pkg::INCSK_MODE_INDEXED:
                next_addr = indexBase + {4'h0, decoded.offset};
            default:
                next_addr = (decoded.offset >= incsk_pkg::ACCESS_SPLIT)
                          ? {incsk_pkg::ACCESS_HI_BANK, decoded.offset}
                          : {incsk_pkg::ACCESS_LO_BANK, decoded.offset};
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            held <= '0;
        end else if (acceptWord) begin
            held       <= decoded;
            held.valid <= decoded.valid && instrValid;
        end
    end

    // address kept for read and write
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            memAddr <= incsk_pkg::ADDR_RESET;
        end else if (acceptWord) begin
            memAddr <= next_addr;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            twoWordHeld <= 1'b0;
        end else if (acceptWord) begin
            twoWordHeld <= nextIsTwoWord;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            operand <= incsk_pkg::BYTE_RESET;
        end else if (readStep && state == INCSK_EXEC) begin
            operand <= memReadData;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            result <= incsk_pkg::BYTE_RESET;
        end else if (processStep && state == INCSK_EXEC) begin
            result <= operand + 8'h01;
        end
    end

    // zero after the 8-bit wrap from FF
    assign resultZero = (result == 8'h00);
    assign takeSkip   = held.skipIfZero ? resultZero : !resultZero;

    assign writeMem = cycleEnd && (state == INCSK_EXEC) && held.toMemory;
    assign writeAcc = cycleEnd && (state == INCSK_EXEC) && !held.toMemory;

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            memWrite     <= 1'b0;
            memWriteData <= incsk_pkg::BYTE_RESET;
        end else begin
            memWrite <= writeMem;
            if (writeMem) begin
                memWriteData <= result;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            accWrite     <= 1'b0;
            accWriteData <= incsk_pkg::BYTE_RESET;
        end else begin
            accWrite <= writeAcc;
            if (writeAcc) begin
                accWriteData <= result;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            state <= INCSK_IDLE;
        end else begin
            unique case (state)
                INCSK_IDLE: begin
                    if (acceptWord && decoded.valid && instrValid) begin
                        state <= INCSK_EXEC;
                    end
                end
                INCSK_EXEC: begin
                    if (cycleEnd) begin
                        state <= takeSkip ? INCSK_NOP1 : INCSK_IDLE;
                    end
                end
                INCSK_NOP1: begin
                    if (cycleEnd) begin
                        state <= twoWordHeld ? INCSK_NOP2 : INCSK_IDLE;
                    end
                end
                INCSK_NOP2: begin
                    if (cycleEnd) begin
                        state <= INCSK_IDLE;
                    end
                end
            endcase
        end
    end

    assign discardFetched = (state == INCSK_EXEC) && cycleEnd && takeSkip;
    assign nopCycle       = (state == INCSK_NOP1) || (state == INCSK_NOP2);
    assign memRead        = (state == INCSK_EXEC) && (phase == incsk_pkg::PHASE_READ);
    assign busy           = (state != INCSK_IDLE);

endmodule // incsk_core

`default_nettype wire

// [rtl/incsk_decoder.sv]
`timescale 1ns/100ps
`default_nettype none

module incsk_decoder (
    input  wire logic [15:0]         instrWord,
    input  wire logic                extendedSet,
    output incsk_pkg::incsk_decode_t decoded
);

    logic [5:0] opcode;

    assign opcode = instrWord[incsk_pkg::OPC_MSB:incsk_pkg::OPC_LSB];

    always_comb begin
        decoded.valid      = (opcode == incsk_pkg::OPC_SKIP_ZERO)
                           || (opcode == incsk_pkg::OPC_SKIP_NONZERO);
        decoded.skipIfZero = (opcode == incsk_pkg::OPC_SKIP_ZERO);
        decoded.toMemory   = instrWord[incsk_pkg::DEST_BIT];
        decoded.offset     = instrWord[7:0];
        if (instrWord[incsk_pkg::BANK_BIT]) begin
            decoded.mode = incsk_pkg::INCSK_MODE_BANKED;
        end else if (extendedSet && (instrWord[7:0] <= incsk_pkg::INDEXED_LIMIT)) begin
            decoded.mode = incsk_pkg::INCSK_MODE_INDEXED;
        end else begin
            decoded.mode = incsk_pkg::INCSK_MODE_ACCESS;
        end
    end

endmodule // incsk_decoder

`default_nettype wire

// [rtl/incsk_pkg.sv]
package incsk_pkg;

    localparam logic [5:0]  OPC_SKIP_ZERO    = 6'h0F;
    localparam logic [5:0]  OPC_SKIP_NONZERO = 6'h12;
    localparam int          OPC_MSB          = 15;
    localparam int          OPC_LSB          = 10;
    localparam int          DEST_BIT         = 9;
    localparam int          BANK_BIT         = 8;
    localparam logic [7:0]  INDEXED_LIMIT    = 8'h5F;
    localparam logic [7:0]  ACCESS_SPLIT     = 8'h60;
    localparam logic [3:0]  ACCESS_HI_BANK   = 4'hF;
    localparam logic [3:0]  ACCESS_LO_BANK   = 4'h0;
    localparam logic [1:0]  PHASE_RESET      = 2'h0;
    localparam logic [1:0]  PHASE_DECODE     = 2'h0;
    localparam logic [1:0]  PHASE_READ       = 2'h1;
    localparam logic [1:0]  PHASE_PROCESS    = 2'h2;
    localparam logic [1:0]  PHASE_WRITE      = 2'h3;
    localparam logic [11:0] ADDR_RESET       = 12'h000;
    localparam logic [7:0]  BYTE_RESET       = 8'h00;

    typedef enum logic [1:0] {
        INCSK_MODE_ACCESS,
        INCSK_MODE_BANKED,
        INCSK_MODE_INDEXED
    } incsk_mode_t;

    typedef struct packed {
        logic        valid;
        logic        skipIfZero;
        logic        toMemory;
        incsk_mode_t mode;
        logic [7:0]  offset;
    } incsk_decode_t;

    typedef struct packed {
        logic [11:0] addr;
        logic [7:0]  data;
    } incsk_mem_wr_t;

endpackage : incsk_pkg
